//--- lbam_checker.sv
`default_nettype none
module lbam_checker #(parameter int CYCLE_CLKS = 16) (
  input wire clk,
  input wire reset,
  input wire [7:0] bucket_level,
  input wire cycle_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // one fault or one leak per cycle, so the level steps by one at most, except when a fault cycle drops it to a capacity written below it
  chk_step_one: assert property (bucket_level != $past(bucket_level) |->
    bucket_level == $past(bucket_level) + 8'h01 || bucket_level == $past(bucket_level) - 8'h01)
    else $error("level moved by more than one");
  chk_no_wrap: assert property ($past(bucket_level) == 8'h00 |-> bucket_level != 8'hff)
    else $error("level wrapped below zero");
  chk_top_hold: assert property ($past(bucket_level) == 8'hff |-> bucket_level != 8'h00)
    else $error("level wrapped above top");
  chk_tick_single: assert property (cycle_tick |=> !cycle_tick)
    else $error("tick longer than one cycle");
  chk_tick_period: assert property (cycle_tick |-> ##CYCLE_CLKS cycle_tick)
    else $error("monitoring cycle length wrong");
endmodule // lbam_checker
bind lbam_leaky_bucket_activity_monitor lbam_checker #(.CYCLE_CLKS(CYCLE_CLKS)) chk_i (.clk(clk), .reset(reset),
  .bucket_level(bucket_level), .cycle_tick(cycle_tick));
`default_nettype wire

//--- lbam_defs.vh
`ifndef LBAM_DEFS_VH
`define LBAM_DEFS_VH
`define LBAM_ADDR_CAPACITY 12'h000
`define LBAM_ADDR_LEAK 12'h004
`define LBAM_ADDR_LEVEL 12'h008
`define LBAM_ADDR_STATUS 12'h00c
`define LBAM_ADDR_MASK 12'h010
`define LBAM_RST_CAPACITY 8'h08
`define LBAM_RST_LEAK 8'h01
`define LBAM_LEAK_LSB 0
`define LBAM_LEAK_MSB 1
`define LBAM_ST_FAULT 0
`define LBAM_ST_FULL 1
`define LBAM_ST_EMPTY 2
`define LBAM_CYCLE_MS 128
`define LBAM_CLK_KHZ 40000
`define LBAM_CYCLE_CLKS (`LBAM_CYCLE_MS * `LBAM_CLK_KHZ)
`endif

//--- lbam_leaky_bucket_activity_monitor.v
// Behaviour
// RL1 - each faulty monitoring cycle adds one to the accumulator
// RL2 - each run of 1, 2, 4 or 8 clean cycles subtracts one
// RL3 - leak field bits [1:0] select 128, 256, 512 or 1024 ms per leak
// RL4 - accumulator stops at the programmed bucket size despite further faults
// RL5 - a leak due while empty leaves the accumulator at zero
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "lbam_defs.vh"
`default_nettype none
module lbam_leaky_bucket_activity_monitor #(
  parameter [31:0] CYCLE_CLKS = `LBAM_CYCLE_CLKS
) (
  input wire clk,
  input wire reset,
  input wire fault_pin,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [7:0] bucket_level,
  output reg cycle_tick,
  output wire irq
);
  reg [2:0] fault_sync_reg;
  reg fault_seen_reg;
  reg [31:0] cyc_cnt_reg;
  reg [2:0] clean_cnt_reg;
  reg [7:0] capacity_reg;
  reg [7:0] leak_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg [7:0] level_next;
  reg [2:0] ev;
  wire wr;
  wire rd;
  wire [2:0] clean_need;
  wire leak_due;
  wire cyc_end;
  wire map_hit;
  wire [4:0] sel;
  reg fault_filt_reg;

  // one-hot select, shared by the write strobes, the error flag and the read mux
  function [4:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        `LBAM_ADDR_CAPACITY: reg_sel = 5'h01;
        `LBAM_ADDR_LEAK: reg_sel = 5'h02;
        `LBAM_ADDR_LEVEL: reg_sel = 5'h04;
        `LBAM_ADDR_STATUS: reg_sel = 5'h08;
        `LBAM_ADDR_MASK: reg_sel = 5'h10;
        default: reg_sel = 5'h00;
      endcase
    end
  endfunction

  // clean cycles already counted before the one that leaks: 0, 1, 3 or 7
  function [2:0] leak_span;
    input [1:0] code;
    begin
      case (code)
        2'h0: leak_span = 3'h0;
        2'h1: leak_span = 3'h1;
        2'h2: leak_span = 3'h3;
        default: leak_span = 3'h7;
      endcase
    end
  endfunction

  assign pready = 1'b1;
  assign sel = reg_sel(paddr);
  assign map_hit = |sel;
  assign pslverr = psel && penable && !map_hit;
  assign wr = psel && penable && pwrite && map_hit;
  // read data is loaded in the setup cycle so it stands at the access edge
  assign rd = psel && !penable && !pwrite;
  assign irq = |(status_reg & mask_reg);
  assign cyc_end = (cyc_cnt_reg == CYCLE_CLKS - 32'h1);
  // runs of 1/2/4/8 cycles on a 128 ms timebase give 128..1024 ms per leak
  assign clean_need = leak_span(leak_reg[`LBAM_LEAK_MSB:`LBAM_LEAK_LSB]); // RL3
  assign leak_due = cyc_end && !fault_seen_reg && (clean_cnt_reg >= clean_need); // RL2

  always @* begin
    level_next = bucket_level;
    ev = 3'h0;
    if (cyc_end) begin
      if (fault_seen_reg) begin
        ev[`LBAM_ST_FAULT] = 1'b1;
        if (bucket_level < capacity_reg) begin
          level_next = bucket_level + 8'h1; // RL1
        end else begin
          level_next = capacity_reg; // RL4
          ev[`LBAM_ST_FULL] = 1'b1;
        end
      end else if (leak_due) begin
        if (bucket_level != 8'h00) begin
          level_next = bucket_level - 8'h1; // RL2
          ev[`LBAM_ST_EMPTY] = (bucket_level == 8'h01);
        end else begin
          level_next = 8'h00; // RL5
        end
      end
    end
  end

  // stage one may go metastable; only stages two and three are looked at
  always @(posedge clk) begin
    if (reset) begin
      fault_sync_reg <= 3'h0;
    end else begin
      fault_sync_reg <= {fault_sync_reg[1:0], fault_pin};
    end
  end

  // the filtered level moves only once stages two and three agree
  always @(posedge clk) begin
    if (reset) begin
      fault_filt_reg <= 1'b0;
    end else if (fault_sync_reg[2] == fault_sync_reg[1]) begin
      fault_filt_reg <= fault_sync_reg[2];
    end
  end

  // monitoring-cycle timebase; reset restarts the cycle
  always @(posedge clk) begin
    if (reset) begin
      cyc_cnt_reg <= 32'h0;
      cycle_tick <= 1'b0;
    end else begin
      cycle_tick <= cyc_end;
      if (cyc_end) begin
        cyc_cnt_reg <= 32'h0;
      end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
      end
    end
  end

  // a fault in any clock of the cycle but its last marks the whole cycle faulty; one seen only in the last clock is dropped
  always @(posedge clk) begin
    if (reset) begin
      fault_seen_reg <= 1'b0;
    end else if (cyc_end) begin
      fault_seen_reg <= 1'b0;
    end else if (fault_filt_reg) begin
      fault_seen_reg <= 1'b1; // RL1
    end
  end

  // any fault or any leak starts the clean run over
  always @(posedge clk) begin
    if (reset) begin
      clean_cnt_reg <= 3'h0;
    end else if (cyc_end) begin
      if (fault_seen_reg || leak_due) begin
        clean_cnt_reg <= 3'h0;
      end else begin
        clean_cnt_reg <= clean_cnt_reg + 3'h1; // RL2
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      bucket_level <= 8'h00;
    end else begin
      bucket_level <= level_next; // RL1 RL4 RL5
    end
  end

  // leak bits [7:2] are not kept and read back as zero
  always @(posedge clk) begin
    if (reset) begin
      capacity_reg <= `LBAM_RST_CAPACITY;
      leak_reg <= `LBAM_RST_LEAK;
      mask_reg <= 3'h0;
    end else begin
      if (wr && sel[0]) begin
        capacity_reg <= pwdata[7:0];
      end
      if (wr && sel[1]) begin
        leak_reg <= {6'h00, pwdata[1:0]};
      end
      if (wr && sel[4]) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      status_reg <= 3'h0;
    end else if (wr && sel[3]) begin
      status_reg <= (status_reg & ~pwdata[2:0]) | ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (rd) begin
      case (sel)
        5'h01: prdata <= {24'h0, capacity_reg};
        5'h02: prdata <= {24'h0, leak_reg};
        5'h04: prdata <= {24'h0, bucket_level};
        5'h08: prdata <= {29'h0, status_reg};
        5'h10: prdata <= {29'h0, mask_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end
endmodule // lbam_leaky_bucket_activity_monitor
`default_nettype wire

//--- tb_lbam_leaky_bucket_activity_monitor.sv
`default_nettype none
module tb_lbam_leaky_bucket_activity_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, fault_pin = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cycle_tick, irq;
  logic [7:0] bucket_level;
  int n_mismatch = 0, cmp_count = 0;
  logic last_err = 0;
  logic [31:0] rd_data = 32'h0;
  lbam_leaky_bucket_activity_monitor #(.CYCLE_CLKS(32'd16)) DUT (.clk(clk), .reset(reset), .fault_pin(fault_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bucket_level(bucket_level), .cycle_tick(cycle_tick), .irq(irq));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    last_err = pslverr;
    rd_data = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff cycle_tick === 1'b1);
    @(posedge clk);
  endtask
  task automatic t_fill_drain;
    xfer(1, 12'h000, 32'h3); xfer(1, 12'h004, 32'h0); xfer(1, 12'h010, 32'h2);
    fault_pin <= 1; ticks(6);
    chk(bucket_level, 8'h03);
    xfer(0, 12'h008, 32'h0);
    chk(rd_data, 32'h3);
    chk(irq, 1'b1);
    fault_pin <= 0; ticks(2);
    chk(bucket_level, 8'h02);
    xfer(1, 12'h00c, 32'h7);
    chk(irq, 1'b0);
    ticks(5);
    chk(bucket_level, 8'h00);
    ticks(2);
    chk(bucket_level, 8'h00);
    xfer(0, 12'h00c, 32'h0);
    chk(rd_data, 32'h4);
    $display("test fill_drain done");
  endtask
  task automatic t_slow_leak;
    xfer(1, 12'h000, 32'h1); xfer(1, 12'h004, 32'h3); xfer(0, 12'h004, 32'h0);
    chk(rd_data, 32'h3);
    chk(last_err, 1'b0);
    fault_pin <= 1; ticks(3); fault_pin <= 0; ticks(2);
    chk(bucket_level, 8'h01);
    ticks(6);
    chk(bucket_level, 8'h01);
    ticks(2);
    chk(bucket_level, 8'h00);
    xfer(0, 12'h0f0, 32'h0);
    chk(rd_data, 32'h0);
    chk(last_err, 1'b1);
    $display("test slow_leak done");
  endtask
  task automatic t_mid_leak;
    xfer(1, 12'h000, 32'h2); xfer(1, 12'h004, 32'h1);
    fault_pin <= 1; ticks(3); fault_pin <= 0; ticks(2);
    chk(bucket_level, 8'h02);
    ticks(1);
    chk(bucket_level, 8'h01);
    xfer(1, 12'h004, 32'h2);
    ticks(3);
    chk(bucket_level, 8'h01);
    ticks(1);
    chk(bucket_level, 8'h00);
    $display("test mid_leak done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_fill_drain();
    t_slow_leak();
    t_mid_leak();
    complete_run();
  end
  initial begin
    #200us n_mismatch++;
    complete_run();
  end
endmodule // tb_lbam_leaky_bucket_activity_monitor
`default_nettype wire
